// [hw/msat_dev.sv]
// Chosen here: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module msat_dev (
   input wire logic clk,
   input wire logic arst_n,
   msat_if.dev link,
   output logic [5:0] angle,
   output logic [1:0] resolution,
   output logic [1:0] cfg_ms,
   output logic step_taken,
   output logic run_taken,
   output logic frame_error
);

   // The whole state of the translator in one record.
   typedef struct packed {
      logic step_q;
      logic sck_q;
      logic strb_q;
      logic [15:0] shift_in;
      logic [4:0] nbits;
      logic [15:0] shift_out;
      logic [5:0] angle;
      logic [1:0] cfg_ms;
      logic [1:0] res;
      logic step_ev;
      logic run_ev;
      logic frame_err;
   } msat_dev_st_t;

   msat_dev_st_t s_r;
   msat_dev_st_t s_nxt;

   logic [1:0] ms_eff;
   logic step_rise;
   logic sck_rise;
   logic sck_fall;
   logic strb_fall;
   logic strb_rise;
   logic [5:0] ang;

   // Next grid position from a, strictly beyond it in the chosen sense; 6-bit sums wrap by nature.
   function automatic logic [5:0] msat_next_pos(input logic [5:0] a, input logic [1:0] res, input logic fwd);
      logic [5:0] pitch;
      logic [5:0] offs;
      logic [5:0] mask;
      logic [5:0] b;
      logic [5:0] r;
      // Sixteenth resolution is the fallback, so the step size is never zero.
      pitch = msat_pkg::PITCH_SIXTEENTH;
      offs = msat_pkg::OFFSET_NONE;
      unique case (res)
         msat_pkg::RES_FULL: begin
            pitch = msat_pkg::PITCH_FULL;
            offs = msat_pkg::OFFSET_FULL;
         end
         msat_pkg::RES_HALF: begin
            pitch = msat_pkg::PITCH_HALF;
         end
         msat_pkg::RES_QUARTER: begin
            pitch = msat_pkg::PITCH_QUARTER;
         end
         msat_pkg::RES_SIXTEENTH: begin
            pitch = msat_pkg::PITCH_SIXTEENTH;
         end
      endcase
      // Full step is the 16-pitch grid moved by eight, so both phases carry current there.
      mask = pitch - 6'h01;
      b = a - offs;
      // An off-grid angle snaps to the neighbouring grid point; an on-grid one moves a whole pitch.
      if (fwd) begin
         r = (b & ~mask) + pitch;
      end else if ((b & mask) != 6'h00) begin
         r = b & ~mask;
      end else begin
         r = b - pitch;
      end
      return r + offs;
   endfunction

   // Fault register 1 image; the diagnostic flags are outside this block and read as zero.
   function automatic logic [15:0] msat_fault1_word(input logic [5:0] a);
      return {msat_pkg::FAULT1_UPPER, a};
   endfunction

   // Edge detection on the pins; pins are synchronous to clk so one stage of history suffices.
   // The history flops reset to the idle pin levels, so no false edge follows reset.
   assign step_rise = link.step & ~s_r.step_q;
   assign sck_rise = link.sck & ~s_r.sck_q;
   assign sck_fall = ~link.sck & s_r.sck_q;
   assign strb_fall = ~link.serial_strobe_low & s_r.strb_q;
   assign strb_rise = link.serial_strobe_low & ~s_r.strb_q;

   // The pin level and the stored bit are merged so either path can raise the resolution.
   // A pin held high locks its bit, which is why register-only control needs the pins low.
   assign ms_eff = {link.microstep_select_hi | s_r.cfg_ms[1],
                    link.microstep_select_lo | s_r.cfg_ms[0]};

   // Next-state logic: step edge first, then a committed serial frame, so both land in one cycle.
   always_comb begin
      s_nxt = s_r;
      ang = s_r.angle;
      s_nxt.step_ev = 1'b0;
      s_nxt.run_ev = 1'b0;
      s_nxt.frame_err = 1'b0;
      s_nxt.step_q = link.step;
      s_nxt.sck_q = link.sck;
      s_nxt.strb_q = link.serial_strobe_low;

      // Resolution and direction are taken fresh at every rising step edge.
      if (step_rise) begin
         ang = msat_next_pos(ang, ms_eff, link.dir);
         s_nxt.res = ms_eff;
         s_nxt.step_ev = 1'b1;
      end

      // A new frame starts the bit count and loads the readback image.
      if (strb_fall) begin
         s_nxt.nbits = '0;
         s_nxt.shift_out = msat_fault1_word(s_r.angle);
      end else if (!link.serial_strobe_low) begin
         if (sck_rise) begin
            s_nxt.shift_in = {s_r.shift_in[14:0], link.sdi};
            // Saturate so a long frame cannot wrap back to a valid length.
            if (s_r.nbits != 5'h1f) begin
               s_nxt.nbits = s_r.nbits + 5'h01;
            end
         end
         // Output moves on the falling edge so the host samples a settled bit on the rise.
         if (sck_fall) begin
            s_nxt.shift_out = {s_r.shift_out[14:0], 1'b0};
         end
      end

      // Only the strobe's rising edge commits, so the serial clock rate never sets the step rate.
      if (strb_rise) begin
         if (s_r.nbits == 5'(msat_pkg::FRAME_BITS)) begin
            unique case (s_r.shift_in[msat_pkg::ADDR_MSB:msat_pkg::ADDR_LSB])
               msat_pkg::ADDR_CFG0: begin
                  s_nxt.cfg_ms = {s_r.shift_in[msat_pkg::CFG_MS_HI_BIT], s_r.shift_in[msat_pkg::CFG_MS_LO_BIT]};
               end
               msat_pkg::ADDR_RUN: begin
                  // Plain modulo-64 add of the signed field; select bits play no part here.
                  ang = ang + s_r.shift_in[msat_pkg::SC_MSB:0];
                  s_nxt.run_ev = 1'b1;
               end
               msat_pkg::ADDR_FAULT1: begin
                  s_nxt.run_ev = 1'b0;
               end
               default: begin
                  s_nxt.run_ev = 1'b0;
               end
            endcase
         end else begin
            // A cut or overlong frame is dropped whole and only flagged.
            s_nxt.frame_err = 1'b1;
         end
      end

      // One final assignment, so a step and a run commit in the same cycle both count.
      s_nxt.angle = ang;
   end

   // State register; the stored select bits clear so the pins alone decide after reset.
   // The angle reset value is a free choice, since nothing fixes where the motor starts.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_r <= '{step_q: 1'b0, sck_q: 1'b0, strb_q: 1'b1, shift_in: 16'h0000, nbits: 5'h00,
                  shift_out: 16'h0000, angle: msat_pkg::ANGLE_RST, cfg_ms: msat_pkg::CFG_MS_RST,
                  res: msat_pkg::RES_FULL, step_ev: 1'b0, run_ev: 1'b0, frame_err: 1'b0};
      end else begin
         s_r <= s_nxt;
      end
   end

   // All outputs come straight from the state register.
   assign link.sdo = s_r.shift_out[15];
   assign angle = s_r.angle;
   assign resolution = s_r.res;
   assign cfg_ms = s_r.cfg_ms;
   assign step_taken = s_r.step_ev;
   assign run_taken = s_r.run_ev;
   assign frame_error = s_r.frame_err;

endmodule // msat_dev
`default_nettype wire

// [hw/msat_pkg.sv]
// Shared constants for the microstep angle translator and the controller that drives it.
package msat_pkg;

   // Angle and serial frame geometry.
   localparam int ANGLE_W = 6;
   localparam int FRAME_BITS = 16;
   localparam int ADDR_MSB = 15;
   localparam int ADDR_LSB = 14;
   localparam int SC_MSB = 5;
   localparam int NBITS_W = 5;

   // Effective microstep select codes, high bit first.
   localparam logic [1:0] RES_FULL = 2'h0;
   localparam logic [1:0] RES_HALF = 2'h1;
   localparam logic [1:0] RES_QUARTER = 2'h2;
   localparam logic [1:0] RES_SIXTEENTH = 2'h3;

   // Grid pitch and offset of the positions each resolution may visit.
   localparam logic [5:0] PITCH_FULL = 6'h10;
   localparam logic [5:0] PITCH_HALF = 6'h08;
   localparam logic [5:0] PITCH_QUARTER = 6'h04;
   localparam logic [5:0] PITCH_SIXTEENTH = 6'h01;
   localparam logic [5:0] OFFSET_FULL = 6'h08;
   localparam logic [5:0] OFFSET_NONE = 6'h00;

   // Serial frame register addresses in bits 15:14.
   localparam logic [1:0] ADDR_CFG0 = 2'h0;
   localparam logic [1:0] ADDR_RUN = 2'h1;
   localparam logic [1:0] ADDR_FAULT1 = 2'h2;

   // Configuration register 0 fields and reset values.
   localparam int CFG_MS_LO_BIT = 0;
   localparam int CFG_MS_HI_BIT = 1;
   localparam logic [1:0] CFG_MS_RST = 2'h0;
   localparam logic [5:0] ANGLE_RST = 6'h00;
   localparam logic [9:0] FAULT1_UPPER = 10'h000;

   // Controller register byte offsets on the Avalon-MM slave.
   localparam int AVS_ADDR_W = 8;
   localparam logic [7:0] REG_PINS = 8'h00;
   localparam logic [7:0] REG_STEP = 8'h04;
   localparam logic [7:0] REG_FRAME = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0c;
   localparam logic [7:0] REG_RXWORD = 8'h10;
   localparam int PINS_DIR_BIT = 0;
   localparam int PINS_MS_LO_BIT = 1;
   localparam int PINS_MS_HI_BIT = 2;
   localparam logic [2:0] PINS_RST = 3'h0;
   localparam int STATUS_BUSY_BIT = 0;

   // Link timing in nanoseconds and derived cycle counts (least times round up).
   localparam int CLK_NS = 25;
   localparam int STEP_HIGH_NS = 1000;
   localparam int STEP_LOW_NS = 1000;
   localparam int SCK_HALF_NS = 250;
   localparam int STRB_LEAD_NS = 250;
   localparam int STRB_GAP_NS = 250;
   localparam int STEP_HIGH_CYC = (STEP_HIGH_NS + CLK_NS - 1) / CLK_NS;
   localparam int STEP_LOW_CYC = (STEP_LOW_NS + CLK_NS - 1) / CLK_NS;
   localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;
   localparam int STRB_LEAD_CYC = (STRB_LEAD_NS + CLK_NS - 1) / CLK_NS;
   localparam int STRB_GAP_CYC = (STRB_GAP_NS + CLK_NS - 1) / CLK_NS;

   typedef logic [7:0] msat_cnt_t;

endpackage

// [hw/msat_if.sv]
`timescale 1ns/1ps
`default_nettype none
// Pins between the host controller and the translator; all levels are plain one-way wires.
interface msat_if;
   logic step;
   logic dir;
   logic microstep_select_hi;
   logic microstep_select_lo;
   logic sck;
   logic sdi;
   logic sdo;
   logic serial_strobe_low;

   modport dev (
      input step,
      input dir,
      input microstep_select_hi,
      input microstep_select_lo,
      input sck,
      input sdi,
      input serial_strobe_low,
      output sdo
   );

   modport host (
      output step,
      output dir,
      output microstep_select_hi,
      output microstep_select_lo,
      output sck,
      output sdi,
      output serial_strobe_low,
      input sdo
   );
endinterface
`default_nettype wire

// [hw/msat_host.sv]
`timescale 1ns/1ps
`default_nettype none
// Host controller: software orders step pulses and serial frames over Avalon-MM.
module msat_host #(
   parameter int STEP_HIGH_CYC = msat_pkg::STEP_HIGH_CYC,
   parameter int STEP_LOW_CYC = msat_pkg::STEP_LOW_CYC,
   parameter int SCK_HALF_CYC = msat_pkg::SCK_HALF_CYC,
   parameter int STRB_LEAD_CYC = msat_pkg::STRB_LEAD_CYC,
   parameter int STRB_GAP_CYC = msat_pkg::STRB_GAP_CYC
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   msat_if.host link
);

   // Counters are eight bits wide, so phase lengths must fit 1 to 256, and the serial half period and strobe lead 2 to 256.
   if (STEP_HIGH_CYC < 1 || STEP_HIGH_CYC > 256 || STEP_LOW_CYC < 1 || STEP_LOW_CYC > 256 ||
       SCK_HALF_CYC < 2 || SCK_HALF_CYC > 256 || STRB_LEAD_CYC < 2 || STRB_LEAD_CYC > 256 ||
       STRB_GAP_CYC < 1 || STRB_GAP_CYC > 256) begin : g_bad_timing
      $error("msat_host timing parameter out of range");
   end

   typedef enum logic [2:0] {PH_IDLE, PH_STEP_HI, PH_GAP, PH_LEAD, PH_SCK_LO, PH_SCK_HI, PH_TAIL} msat_phase_t;

   typedef struct packed {
      msat_phase_t phase;
      msat_pkg::msat_cnt_t cnt;
      logic [2:0] pins;
      logic step;
      logic sck;
      logic strb;
      logic [4:0] bitn;
      logic [15:0] txw;
      logic [15:0] rxw;
      logic [15:0] rxword;
      logic rd_done;
      logic [31:0] rdata;
   } msat_host_st_t;

   msat_host_st_t s_r;
   msat_host_st_t s_nxt;
   logic busy;
   logic wr_go;

   // Writes stall while a pulse or frame runs, so pin levels never move under a high step.
   assign busy = (s_r.phase != PH_IDLE);
   assign wr_go = avs_write && !busy;
   assign avs_waitrequest = (avs_read && !s_r.rd_done) || (avs_write && busy);

   always_comb begin
      s_nxt = s_r;
      // Reads take one wait cycle while the answer is registered.
      s_nxt.rd_done = avs_read && !s_r.rd_done;
      if (avs_read && !s_r.rd_done) begin
         unique case (avs_address)
            msat_pkg::REG_PINS: s_nxt.rdata = {29'h0, s_r.pins};
            msat_pkg::REG_STATUS: s_nxt.rdata = {31'h0, busy};
            msat_pkg::REG_RXWORD: s_nxt.rdata = {16'h0, s_r.rxword};
            default: s_nxt.rdata = 32'h0;
         endcase
      end
      if (s_r.cnt != 8'h00) begin
         s_nxt.cnt = s_r.cnt - 8'h01;
      end
      unique case (s_r.phase)
         PH_IDLE: begin
            if (wr_go && avs_address == msat_pkg::REG_PINS) begin
               s_nxt.pins = avs_writedata[2:0];
            end else if (wr_go && avs_address == msat_pkg::REG_STEP) begin
               s_nxt.step = 1'b1;
               s_nxt.cnt = msat_pkg::msat_cnt_t'(STEP_HIGH_CYC - 1);
               s_nxt.phase = PH_STEP_HI;
            end else if (wr_go && avs_address == msat_pkg::REG_FRAME) begin
               // The word goes out whole, so software supplies every field each time.
               s_nxt.txw = avs_writedata[15:0];
               s_nxt.strb = 1'b0;
               s_nxt.bitn = 5'h00;
               s_nxt.cnt = msat_pkg::msat_cnt_t'(STRB_LEAD_CYC - 1);
               s_nxt.phase = PH_LEAD;
            end
         end
         PH_STEP_HI: begin
            if (s_r.cnt == 8'h00) begin
               s_nxt.step = 1'b0;
               s_nxt.cnt = msat_pkg::msat_cnt_t'(STEP_LOW_CYC - 1);
               s_nxt.phase = PH_GAP;
            end
         end
         PH_GAP: begin
            if (s_r.cnt == 8'h00) begin
               s_nxt.phase = PH_IDLE;
            end
         end
         PH_LEAD, PH_SCK_LO: begin
            if (s_r.cnt == 8'h00) begin
               s_nxt.sck = 1'b1;
               s_nxt.rxw = {s_r.rxw[14:0], link.sdo};
               s_nxt.cnt = msat_pkg::msat_cnt_t'(SCK_HALF_CYC - 1);
               s_nxt.phase = PH_SCK_HI;
            end
         end
         PH_SCK_HI: begin
            if (s_r.cnt == 8'h00) begin
               s_nxt.sck = 1'b0;
               s_nxt.txw = {s_r.txw[14:0], 1'b0};
               s_nxt.bitn = s_r.bitn + 5'h01;
               s_nxt.cnt = msat_pkg::msat_cnt_t'(SCK_HALF_CYC - 1);
               s_nxt.phase = (s_r.bitn == 5'(msat_pkg::FRAME_BITS - 1)) ? PH_TAIL : PH_SCK_LO;
            end
         end
         PH_TAIL: begin
            // The strobe's rise is what commits the frame in the translator.
            if (s_r.cnt == 8'h00) begin
               s_nxt.strb = 1'b1;
               s_nxt.rxword = s_r.rxw;
               s_nxt.cnt = msat_pkg::msat_cnt_t'(STRB_GAP_CYC - 1);
               s_nxt.phase = PH_GAP;
            end
         end
         // The one unused phase code falls back to idle rather than hanging.
         default: begin
            s_nxt.phase = PH_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_r <= '{phase: PH_IDLE, cnt: 8'h00, pins: msat_pkg::PINS_RST, step: 1'b0, sck: 1'b0, strb: 1'b1,
                  bitn: 5'h00, txw: 16'h0000, rxw: 16'h0000, rxword: 16'h0000, rd_done: 1'b0,
                  rdata: 32'h00000000};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign avs_readdata = s_r.rdata;
   assign link.step = s_r.step;
   assign link.dir = s_r.pins[msat_pkg::PINS_DIR_BIT];
   assign link.microstep_select_lo = s_r.pins[msat_pkg::PINS_MS_LO_BIT];
   assign link.microstep_select_hi = s_r.pins[msat_pkg::PINS_MS_HI_BIT];
   assign link.sck = s_r.sck;
   assign link.sdi = s_r.txw[15];
   assign link.serial_strobe_low = s_r.strb;

endmodule // msat_host
`default_nettype wire

// [verification/msat_checker.sv]
`timescale 1ns/1ps
`default_nettype none
// Watches the link pins and the translator's user side; it drives nothing.
module msat_checker (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic step,
   input wire logic dir,
   input wire logic microstep_select_hi,
   input wire logic microstep_select_lo,
   input wire logic sck,
   input wire logic serial_strobe_low,
   input wire logic [5:0] angle,
   input wire logic [1:0] resolution,
   input wire logic [1:0] cfg_ms,
   input wire logic step_taken,
   input wire logic run_taken
);
   // One clock domain, so clocking and reset are stated once for every property.
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   // A step pin rise is taken within two cycles, and only a step or a run commit moves the angle.
   AST_STEP_DETECT: assert property ($rose(step) |-> ##[1:2] step_taken)
      else $error("step rise was not taken");
   AST_ANGLE_CAUSE: assert property ($changed(angle) |-> step_taken || run_taken)
      else $error("angle moved without a step or run commit");
   // The pins cannot move while a step is in flight, so the sum may use present levels.
   AST_RES_OR: assert property (step_taken |-> resolution == ({microstep_select_hi, microstep_select_lo} | cfg_ms))
      else $error("effective resolution is not pin or register");
   AST_GRID_FULL: assert property (step_taken && resolution == msat_pkg::RES_FULL |-> angle[3:0] == 4'h8)
      else $error("full step left the both-phase positions");
   AST_GRID_HALF: assert property (step_taken && resolution == msat_pkg::RES_HALF |-> angle[2:0] == 3'h0)
      else $error("half step left the multiples of eight");
   AST_GRID_QTR: assert property (step_taken && resolution == msat_pkg::RES_QUARTER |-> angle[1:0] == 2'h0)
      else $error("quarter step left the multiples of four");
   AST_SIXTEENTH: assert property (step_taken && !run_taken && resolution == msat_pkg::RES_SIXTEENTH
      |-> angle == ($past(dir) ? 6'($past(angle) + 6'h01) : 6'($past(angle) - 6'h01)))
      else $error("sixteenth step did not move by one");
   // A run commit follows a strobe rise by one or two cycles.
   AST_RUN_WINDOW: assert property (run_taken |-> serial_strobe_low && (!$past(serial_strobe_low, 2) || !$past(serial_strobe_low, 3)))
      else $error("run commit without a strobe rise");
   AST_SCK_IDLE: assert property (serial_strobe_low |-> !sck)
      else $error("serial clock ran outside a frame");
endmodule // msat_checker
`default_nettype wire

// [verification/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, ac) begin total_checks++; if ((ac) !== (ex)) begin err_total++; $display("unexpected %s expected %h seen %h", nm, ex, ac); end end
module tb_top;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [5:0] angle;
   logic [1:0] resolution;
   logic [1:0] cfg_ms;
   logic step_taken;
   logic run_taken;
   logic frame_error;
   logic [31:0] rd;
   int err_total = 0;
   int total_checks = 0;
   int cycles = 0;
   int frm_errs = 0;
   logic [1:0] modes [3] = '{msat_pkg::RES_QUARTER, msat_pkg::RES_HALF, msat_pkg::RES_FULL};
   logic [5:0] snaps [3] = '{6'h3c, 6'h00, 6'h08};
   int backs [3] = '{1, 5, 0};

   msat_if link_if();
   // Short link timings keep the run brief; the low time leaves room for the step to land.
   msat_host #(.STEP_HIGH_CYC(1), .STEP_LOW_CYC(4), .SCK_HALF_CYC(2), .STRB_LEAD_CYC(2), .STRB_GAP_CYC(1)) u_msat_host (
      .clk(clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .link(link_if));
   msat_dev u_msat_dev (.clk(clk), .arst_n(arst_n), .link(link_if), .angle(angle), .resolution(resolution),
      .cfg_ms(cfg_ms), .step_taken(step_taken), .run_taken(run_taken), .frame_error(frame_error));
   msat_checker u_chk (.clk(clk), .arst_n(arst_n), .step(link_if.step), .dir(link_if.dir),
      .microstep_select_hi(link_if.microstep_select_hi), .microstep_select_lo(link_if.microstep_select_lo),
      .sck(link_if.sck), .serial_strobe_low(link_if.serial_strobe_low), .angle(angle), .resolution(resolution),
      .cfg_ms(cfg_ms), .step_taken(step_taken), .run_taken(run_taken));

   // Free-running clock at 40 MHz.
   always #12.5 clk = ~clk;

   // One bus access; the request stands until waitrequest is seen low at a rising edge.
   task automatic av_access(input logic [7:0] a, input logic wr, input logic [31:0] d);
      int n;
      @(posedge clk);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0);
      if (!wr) `CHK("read_waits", 2, n)
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask

   // Polls the busy flag, since writes stall while a pulse or frame runs.
   task automatic wait_idle();
      do begin
         av_access(msat_pkg::REG_STATUS, 1'b0, 32'h0);
      end while (rd[msat_pkg::STATUS_BUSY_BIT] !== 1'b0);
      `CHK("status", 32'h0, rd)
   endtask

   task automatic pins(input logic d, input logic [1:0] ms);
      av_access(msat_pkg::REG_PINS, 1'b1, {29'h0, ms, d});
   endtask

   task automatic step_chk(input logic [5:0] ex);
      av_access(msat_pkg::REG_STEP, 1'b1, 32'h0);
      wait_idle();
      `CHK("angle", ex, angle)
   endtask

   // The angle lands one cycle after the strobe rises, so a few cycles pass before looking.
   task automatic frame_chk(input logic [15:0] w, input logic [5:0] ex);
      av_access(msat_pkg::REG_FRAME, 1'b1, {16'h0, w});
      wait_idle();
      repeat (3) @(posedge clk);
      `CHK("angle", ex, angle)
   endtask

   task automatic finish_test();
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Cuts a hang short; the tests need under a thousand cycles.
   always @(posedge clk) begin
      if (frame_error !== 1'b0) frm_errs++;
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         $display("unexpected cycles expected below 20000 seen 20000");
         finish_test();
      end
   end

   initial begin
      repeat (4) @(posedge clk);
      arst_n <= 1'b1;
      `CHK("angle", msat_pkg::ANGLE_RST, angle)
      `CHK("cfg_ms", msat_pkg::CFG_MS_RST, cfg_ms)
      av_access(8'h20, 1'b0, 32'h0);
      `CHK("unmapped", 32'h0, rd)
      pins(1'b1, msat_pkg::RES_SIXTEENTH);
      step_chk(6'h01);
      pins(1'b0, msat_pkg::RES_SIXTEENTH);
      step_chk(6'h00);
      step_chk(6'h3f);
      for (int i = 0; i < 4; i++) begin
         step_chk(6'(62 - i));
      end
      // From 59 forward, each coarser mode snaps to its next grid point; quarter and half then return to 59, full stays at 8.
      for (int m = 0; m < 3; m++) begin
         pins(1'b1, modes[m]);
         step_chk(snaps[m]);
         pins(1'b0, msat_pkg::RES_SIXTEENTH);
         for (int j = 0; j < backs[m]; j++) begin
            step_chk(6'(snaps[m] - 6'(j + 1)));
         end
      end
      pins(1'b1, msat_pkg::RES_FULL);
      for (int i = 0; i < 4; i++) begin
         step_chk(6'(24 + 16 * i));
      end
      pins(1'b1, msat_pkg::RES_HALF);
      for (int i = 0; i < 4; i++) begin
         step_chk(6'(16 + 8 * i));
      end
      pins(1'b0, msat_pkg::RES_QUARTER);
      step_chk(6'h24);
      step_chk(6'h20);
      pins(1'b0, msat_pkg::RES_FULL);
      step_chk(6'h18);
      // Serial run words add a signed change and ignore the full-step pins.
      frame_chk({msat_pkg::ADDR_RUN, 8'h00, 6'h04}, 6'h1c);
      frame_chk({msat_pkg::ADDR_RUN, 8'h00, 6'h3c}, 6'h18);
      frame_chk({msat_pkg::ADDR_RUN, 8'h00, 6'h30}, 6'h08);
      frame_chk({msat_pkg::ADDR_RUN, 8'h00, 6'h30}, 6'h38);
      frame_chk({msat_pkg::ADDR_RUN, 8'h00, 6'h04}, 6'h3c);
      // Register select bits are ORed with the pins.
      pins(1'b1, msat_pkg::RES_FULL);
      frame_chk({msat_pkg::ADDR_CFG0, 12'h000, 2'h2}, 6'h3c);
      `CHK("cfg_ms", 2'h2, cfg_ms)
      step_chk(6'h00);
      `CHK("resolution", msat_pkg::RES_QUARTER, resolution)
      pins(1'b1, msat_pkg::RES_HALF);
      step_chk(6'h01);
      `CHK("resolution", msat_pkg::RES_SIXTEENTH, resolution)
      frame_chk({msat_pkg::ADDR_FAULT1, 14'h0000}, 6'h01);
      av_access(msat_pkg::REG_RXWORD, 1'b0, 32'h0);
      `CHK("readback", {26'h0, 6'h01}, rd)
      av_access(msat_pkg::REG_PINS, 1'b0, 32'h0);
      `CHK("pins", {29'h0, msat_pkg::RES_HALF, 1'b1}, rd)
      // Park on a both-phase position before the run ends.
      frame_chk({msat_pkg::ADDR_RUN, 8'h00, 6'h07}, 6'h08);
      `CHK("frame_error", 0, frm_errs)
      finish_test();
   end
endmodule // tb_top
`default_nettype wire
